/* drive_input_pkg.sv */
// Constants, register map and carrier types for the drive input terminal decoder.
// Assumes a 100 MHz APB clock and six standard input terminals.
package drive_input_pkg;

	// --------------------------------------------------------------
	// Bus and register map
	// --------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFS_POLARITY = 8'h00;
	localparam logic [7:0] OFS_DEBOUNCE = 8'h04;
	localparam logic [7:0] OFS_FUNCTION = 8'h08;
	localparam logic [7:0] OFS_CONTROL = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// --------------------------------------------------------------
	// Field layouts and reset values
	// --------------------------------------------------------------
	localparam int POLARITY_W = 12;
	localparam logic [11:0] POLARITY_RESET = 12'h000;
	localparam int DEBOUNCE_W = 5;
	localparam logic [4:0] DEBOUNCE_RESET = 5'h01;
	localparam logic [4:0] DEBOUNCE_MIN = 5'h01;
	localparam logic [4:0] DEBOUNCE_MAX = 5'h14;
	localparam int FUNC_W = 5;
	localparam logic [4:0] FUNCTION_RESET = 5'h00;
	localparam int CTRL_CMD_SRC_LSB = 0;
	localparam int CTRL_STOP_METHOD_BIT = 4;
	localparam int CTRL_KEYPAD_STATE_LSB = 8;
	localparam int CTRL_KEYPAD_REQ_BIT = 10;
	localparam logic [2:0] CMD_SRC_RESET = 3'h0;
	localparam int STAT_LEVELS_LSB = 0;
	localparam int STAT_PROGRAM_LSB = 16;
	localparam int STAT_SPEED_LSB = 20;
	localparam int STAT_MASTER_BIT = 24;
	localparam int STAT_MOTOR_LSB = 25;
	localparam int STAT_QUICK_STOP_BIT = 27;

	// --------------------------------------------------------------
	// Terminal function codes and command sources
	// --------------------------------------------------------------
	localparam logic [4:0] FN_NONE = 5'h00;
	localparam logic [4:0] FN_SPEED_BIT0 = 5'h01;
	localparam logic [4:0] FN_PROGRAM_RUN = 5'h17;
	localparam logic [4:0] FN_QUICK_STOP = 5'h17;
	localparam logic [4:0] FN_PROGRAM_DOWNLOAD = 5'h18;
	localparam logic [4:0] FN_MOTOR_BIT0 = 5'h1B;
	localparam logic [4:0] FN_MOTOR_BIT1 = 5'h1C;
	localparam logic [2:0] CMD_SRC_KEYPAD = 3'h0;
	localparam logic [2:0] CMD_SRC_TERMINAL = 3'h1;
	localparam logic [2:0] CMD_SRC_TERMINAL_NO_STOP = 3'h2;
	localparam logic [2:0] CMD_SRC_QUICK_STOP = 3'h5;

	// --------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int DEBOUNCE_STEP_NS = 2000000;
	localparam int DEBOUNCE_STEP_CYCLES = DEBOUNCE_STEP_NS / CLK_PERIOD_NS;

	// --------------------------------------------------------------
	// Types
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		PROGRAM_IDLE_STATE = 2'b00,
		PROGRAM_RUN_STATE = 2'b01,
		PROGRAM_DOWNLOAD_STATE = 2'b11
	} program_state_t;

	typedef struct packed {
		logic [3:0] speed_index;
		logic use_master_frequency;
		logic [1:0] motor_select;
		logic quick_stop;
	} terminal_fn_t;

	typedef struct packed {
		program_state_t state;
		logic execute;
		logic motor_stop_request;
		logic stop_method;
	} program_out_t;

endpackage : drive_input_pkg

/* debounce_filter.sv */
// Per-terminal debounce filter: a level is accepted after it has held
// for a programmed number of step ticks.
// Assumes tick is a one-cycle enable from the caller's divider.
`timescale 1ns/1ps
module debounce_filter #(
	parameter int WIDTH = 6,
	parameter int LEN_W = 5
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	input wire logic [LEN_W-1:0] length,
	input wire logic [WIDTH-1:0] raw,
	output logic [WIDTH-1:0] stable
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic [LEN_W-1:0] count_q;
			logic level_q;

			// A bounce that returns before the count ends restarts the wait
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					count_q <= '0;
					level_q <= 1'b0;
				end else if (raw[i] == level_q) begin
					count_q <= '0;
				end else if (tick) begin
					if (count_q + 1'b1 >= length) begin
						count_q <= '0;
						level_q <= raw[i];
					end else begin
						count_q <= count_q + 1'b1;
					end
				end
			end

			assign stable[i] = level_q;
		end
	endgenerate

endmodule : debounce_filter

/* drive_input_terminal_decode.sv */
// Input terminal conditioning and function decode for a motor drive:
// polarity, debounce, speed and motor select, program state control.
// Assumes an APB master on pclk and terminal pins synchronous to pclk.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps

// Notes on behaviour
// (R1) Run function requests program run, release stops
// (R2) Stopped drive plus run function enters run state
// (R3) Deactivation returns idle, stops motor by method
// (R4) Keypad program changes ignored under terminal source
// (R5) Run function ignored in download state
// (R6) Stopped drive plus download function enters download
// (R7) Download function ignored in run state
// (R8) Quick stop only with command source five
// (R9) Motor select bits form index 0 to 3
// (R10) Speed bits weigh 1,2,4,8; zero selects master
// (R11) Twelve-bit polarity register inverts normally closed inputs
// (R12) Polarity bit n belongs to terminal n+1
// (R13) First three polarity bits ignored in wire modes
// (R14) Debounce N times 2 ms, N 1 to 20
// (R15) Decode uses only corrected, debounced levels
module drive_input_terminal_decode
	import drive_input_pkg::*;
#(
	parameter int NUM_TERMINALS = 6,
	parameter int STEP_CYCLES = DEBOUNCE_STEP_CYCLES,
	parameter bit QUICK_STOP_VARIANT = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [drive_input_pkg::ADDR_W-1:0] paddr,
	input wire logic [drive_input_pkg::DATA_W-1:0] pwdata,
	output logic [drive_input_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_TERMINALS-1:0] input_terminals,
	input wire logic drive_stopped,
	output drive_input_pkg::terminal_fn_t terminal_functions,
	output drive_input_pkg::program_out_t program_out
);
	import drive_input_pkg::*;

	// ------------------------------------------------------------------
	// Registers and shared signals
	// ------------------------------------------------------------------
	logic [POLARITY_W-1:0] input_contact_polarity_q;
	logic [DEBOUNCE_W-1:0] input_debounce_time_q;
	logic [NUM_TERMINALS*FUNC_W-1:0] terminal_function_q;
	logic [2:0] operation_command_source_q;
	logic stop_method_q;
	logic keypad_req_q;
	program_state_t keypad_state_q;
	logic [DATA_W-1:0] prdata_q;
	program_state_t program_state_q;
	logic program_stop_q;
	terminal_fn_t functions_q;
	logic [NUM_TERMINALS-1:0] corrected;
	logic [NUM_TERMINALS-1:0] debounced;
	logic [NUM_TERMINALS-1:0] polarity_mask;
	logic [$clog2(STEP_CYCLES+1)-1:0] step_count_q;
	logic step_tick;
	logic wire_mode;
	logic setup_phase;
	logic write_access;
	logic addr_known;
	logic run_level;
	logic run_level_q;
	logic download_level;
	logic download_level_q;
	logic run_assigned;
	logic download_assigned;
	logic [4:0] debounce_wr;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Level of a function: any terminal assigned to it is active
	function automatic logic fn_level(input logic [NUM_TERMINALS*FUNC_W-1:0] map,
			input logic [NUM_TERMINALS-1:0] levels, input logic [4:0] code);
		logic hit;
		hit = 1'b0;
		for (int t = 0; t < NUM_TERMINALS; t++) begin
			if (map[t*FUNC_W +: FUNC_W] == code && levels[t]) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction : fn_level

	// Whether any terminal carries a function at all
	function automatic logic fn_assigned(input logic [NUM_TERMINALS*FUNC_W-1:0] map,
			input logic [4:0] code);
		logic hit;
		hit = 1'b0;
		for (int t = 0; t < NUM_TERMINALS; t++) begin
			if (map[t*FUNC_W +: FUNC_W] == code) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction : fn_assigned

	// ------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------
	// Zero wait states; read data is captured in the setup cycle so the
	// access phase returns it from a flop.
	assign setup_phase = psel && !penable;
	assign write_access = psel && penable && pwrite;
	assign addr_known = (paddr == OFS_POLARITY) || (paddr == OFS_DEBOUNCE) ||
		(paddr == OFS_FUNCTION) || (paddr == OFS_CONTROL) || (paddr == OFS_STATUS);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_known;
	assign prdata = prdata_q;

	// Out-of-range debounce writes are pulled into 1..20
	always_comb begin
		debounce_wr = pwdata[DEBOUNCE_W-1:0];
		if (debounce_wr < DEBOUNCE_MIN) begin
			debounce_wr = DEBOUNCE_MIN;
		end else if (debounce_wr > DEBOUNCE_MAX) begin
			debounce_wr = DEBOUNCE_MAX;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_contact_polarity_q <= POLARITY_RESET; // R11
			input_debounce_time_q <= DEBOUNCE_RESET;
			terminal_function_q <= {NUM_TERMINALS{FUNCTION_RESET}};
			operation_command_source_q <= CMD_SRC_RESET;
			stop_method_q <= 1'b0;
		end else if (write_access) begin
			unique case (paddr)
				OFS_POLARITY: input_contact_polarity_q <= pwdata[POLARITY_W-1:0]; // R11
				OFS_DEBOUNCE: input_debounce_time_q <= debounce_wr; // R14
				OFS_FUNCTION: terminal_function_q <= pwdata[NUM_TERMINALS*FUNC_W-1:0];
				OFS_CONTROL: begin
					operation_command_source_q <= pwdata[CTRL_CMD_SRC_LSB +: 3];
					stop_method_q <= pwdata[CTRL_STOP_METHOD_BIT];
				end
				default: ;
			endcase
		end
	end

	// Keypad program request: a one-shot write, dropped entirely while the
	// terminals own the operation command.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			keypad_req_q <= 1'b0;
			keypad_state_q <= PROGRAM_IDLE_STATE;
		end else begin
			keypad_req_q <= 1'b0;
			if (write_access && paddr == OFS_CONTROL && pwdata[CTRL_KEYPAD_REQ_BIT] &&
					!wire_mode) begin // R4
				keypad_req_q <= 1'b1;
				keypad_state_q <= program_state_t'(pwdata[CTRL_KEYPAD_STATE_LSB +: 2]);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
		end else if (setup_phase && !pwrite) begin
			prdata_q <= '0;
			unique case (paddr)
				OFS_POLARITY: prdata_q[POLARITY_W-1:0] <= input_contact_polarity_q;
				OFS_DEBOUNCE: prdata_q[DEBOUNCE_W-1:0] <= input_debounce_time_q;
				OFS_FUNCTION: prdata_q[NUM_TERMINALS*FUNC_W-1:0] <= terminal_function_q;
				OFS_CONTROL: begin
					prdata_q[CTRL_CMD_SRC_LSB +: 3] <= operation_command_source_q;
					prdata_q[CTRL_STOP_METHOD_BIT] <= stop_method_q;
				end
				OFS_STATUS: begin
					prdata_q[STAT_LEVELS_LSB +: NUM_TERMINALS] <= debounced;
					prdata_q[STAT_PROGRAM_LSB +: 2] <= program_state_q;
					prdata_q[STAT_SPEED_LSB +: 4] <= functions_q.speed_index;
					prdata_q[STAT_MASTER_BIT] <= functions_q.use_master_frequency;
					prdata_q[STAT_MOTOR_LSB +: 2] <= functions_q.motor_select;
					prdata_q[STAT_QUICK_STOP_BIT] <= functions_q.quick_stop;
				end
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Polarity correction and debounce
	// ------------------------------------------------------------------
	// Two- and three-wire modes use the first terminals as run and
	// direction contacts, so their polarity setting must not flip them.
	assign wire_mode = (operation_command_source_q == CMD_SRC_TERMINAL) ||
		(operation_command_source_q == CMD_SRC_TERMINAL_NO_STOP);

	always_comb begin
		polarity_mask = input_contact_polarity_q[NUM_TERMINALS-1:0]; // R12
		if (wire_mode) begin
			polarity_mask[2:0] = 3'h0; // R13
		end
	end

	assign corrected = input_terminals ^ polarity_mask; // R11

	// Divider giving one 2 ms step tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_count_q <= '0;
		end else if (step_count_q == ($bits(step_count_q))'(STEP_CYCLES - 1)) begin
			step_count_q <= '0;
		end else begin
			step_count_q <= step_count_q + 1'b1;
		end
	end

	assign step_tick = (step_count_q == ($bits(step_count_q))'(STEP_CYCLES - 1));

	debounce_filter #(
		.WIDTH(NUM_TERMINALS),
		.LEN_W(DEBOUNCE_W)
	) u_debounce (
		.pclk(pclk),
		.presetn(presetn),
		.tick(step_tick), // R14
		.length(input_debounce_time_q),
		.raw(corrected),
		.stable(debounced) // R15
	);

	// ------------------------------------------------------------------
	// Function decode
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			functions_q <= '0;
			functions_q.use_master_frequency <= 1'b1;
		end else begin
			for (int b = 0; b < 4; b++) begin
				functions_q.speed_index[b] <= fn_level(terminal_function_q, debounced,
					FN_SPEED_BIT0 + 5'(b)); // R10
			end
			functions_q.use_master_frequency <= !(fn_level(terminal_function_q, debounced,
				FN_SPEED_BIT0) || fn_level(terminal_function_q, debounced, 5'h02) ||
				fn_level(terminal_function_q, debounced, 5'h03) ||
				fn_level(terminal_function_q, debounced, 5'h04)); // R10
			functions_q.motor_select[0] <= fn_level(terminal_function_q, debounced,
				FN_MOTOR_BIT0); // R9
			functions_q.motor_select[1] <= fn_level(terminal_function_q, debounced,
				FN_MOTOR_BIT1); // R9
			functions_q.quick_stop <= QUICK_STOP_VARIANT &&
				operation_command_source_q == CMD_SRC_QUICK_STOP &&
				fn_level(terminal_function_q, debounced, FN_QUICK_STOP); // R8
		end
	end

	assign terminal_functions = functions_q;

	// ------------------------------------------------------------------
	// Program state machine
	// ------------------------------------------------------------------
	// The quick stop variant shares code 23; its terminals never drive the program engine, only the keypad does.
	assign run_level = !QUICK_STOP_VARIANT &&
		fn_level(terminal_function_q, debounced, FN_PROGRAM_RUN); // R15
	assign download_level = !QUICK_STOP_VARIANT &&
		fn_level(terminal_function_q, debounced, FN_PROGRAM_DOWNLOAD);
	assign run_assigned = fn_assigned(terminal_function_q, FN_PROGRAM_RUN);
	assign download_assigned = fn_assigned(terminal_function_q, FN_PROGRAM_DOWNLOAD);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_level_q <= 1'b0;
			download_level_q <= 1'b0;
		end else begin
			run_level_q <= run_level;
			download_level_q <= download_level;
		end
	end

	// Entry is level driven, so a function held on through a run waits for
	// the drive to stop; exit is edge driven so the keypad can still act
	// when no terminal is assigned.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			program_state_q <= PROGRAM_IDLE_STATE;
			program_stop_q <= 1'b0;
		end else begin
			program_stop_q <= 1'b0;
			unique case (program_state_q)
				PROGRAM_IDLE_STATE: begin
					if (drive_stopped && run_level) begin
						program_state_q <= PROGRAM_RUN_STATE; // R1 R2
					end else if (drive_stopped && download_level) begin
						program_state_q <= PROGRAM_DOWNLOAD_STATE; // R6
					end else if (keypad_req_q && drive_stopped &&
							(keypad_state_q == PROGRAM_RUN_STATE ||
							keypad_state_q == PROGRAM_DOWNLOAD_STATE)) begin
						program_state_q <= keypad_state_q;
					end
				end
				PROGRAM_RUN_STATE: begin
					// Download function has no say here
					if (run_assigned && run_level_q && !run_level) begin // R7
						program_state_q <= PROGRAM_IDLE_STATE; // R1 R3
						program_stop_q <= 1'b1; // R3
					end else if (keypad_req_q && keypad_state_q == PROGRAM_IDLE_STATE) begin
						program_state_q <= PROGRAM_IDLE_STATE;
						program_stop_q <= 1'b1;
					end
				end
				PROGRAM_DOWNLOAD_STATE: begin
					// Run function has no say here
					if (download_assigned && download_level_q && !download_level) begin // R5
						program_state_q <= PROGRAM_IDLE_STATE; // R3
						program_stop_q <= 1'b1; // R3
					end else if (keypad_req_q && keypad_state_q == PROGRAM_IDLE_STATE) begin
						program_state_q <= PROGRAM_IDLE_STATE;
						program_stop_q <= 1'b1;
					end
				end
				default: begin
					program_state_q <= PROGRAM_IDLE_STATE;
				end
			endcase
		end
	end

	always_comb begin
		program_out.state = program_state_q;
		program_out.execute = program_state_q != PROGRAM_IDLE_STATE;
		program_out.motor_stop_request = program_stop_q; // R3
		program_out.stop_method = stop_method_q; // R3
	end

endmodule : drive_input_terminal_decode

/* drive_input_terminal_decode_props.sv */
// Checker for the input terminal decoder: bus answers, decode and program state moves.
// Assumes it is bound to the decoder top and sees only that module's ports.
`timescale 1ns/1ps
module drive_input_terminal_decode_props
	import drive_input_pkg::*;
#(
	parameter int NUM_TERMINALS = 6,
	parameter int STEP_CYCLES = DEBOUNCE_STEP_CYCLES,
	parameter bit QUICK_STOP_VARIANT = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [drive_input_pkg::ADDR_W-1:0] paddr,
	input wire logic [drive_input_pkg::DATA_W-1:0] pwdata,
	input wire logic [drive_input_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NUM_TERMINALS-1:0] input_terminals,
	input wire logic drive_stopped,
	input wire drive_input_pkg::terminal_fn_t terminal_functions,
	input wire drive_input_pkg::program_out_t program_out
);
	// Longest debounce plus decode latency, with margin
	localparam int QUIET = 21 * STEP_CYCLES + 8;
	int quiet_q;
	logic unmapped;
	program_state_t st;
	assign unmapped = !(paddr inside {OFS_POLARITY, OFS_DEBOUNCE, OFS_FUNCTION, OFS_CONTROL,
		OFS_STATUS});
	assign st = program_out.state;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Cycles without pin, stopped-flag or register write activity
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quiet_q <= 0;
		end else if ($changed(input_terminals) || $changed(drive_stopped) || (psel && pwrite)) begin
			quiet_q <= 0;
		end else if (quiet_q <= QUIET) begin
			quiet_q <= quiet_q + 1;
		end
	end
	property p_zero_wait; psel && penable |-> pready; endproperty
	a_zero_wait: assert property (p_zero_wait) else $error("pready low in access phase");
	property p_err; pslverr == (psel && penable && unmapped); endproperty
	a_err: assert property (p_err) else $error("pslverr does not match address");
	property p_rd_hole; psel && penable && !pwrite && unmapped |-> prdata == '0; endproperty
	a_rd_hole: assert property (p_rd_hole) else $error("unmapped read not zero");
	property p_master; terminal_functions.use_master_frequency == (terminal_functions.speed_index == 4'h0); endproperty
	a_master: assert property (p_master) else $error("master frequency flag wrong");
	property p_execute; program_out.execute == (st != PROGRAM_IDLE_STATE); endproperty
	a_execute: assert property (p_execute) else $error("execute disagrees with state");
	property p_stop_pulse;
		program_out.motor_stop_request == ($past(st) != PROGRAM_IDLE_STATE && st == PROGRAM_IDLE_STATE);
	endproperty
	a_stop_pulse: assert property (p_stop_pulse) else $error("stop pulse wrong");
	property p_entry; $past(st) == PROGRAM_IDLE_STATE && st != PROGRAM_IDLE_STATE |-> $past(drive_stopped); endproperty
	a_entry: assert property (p_entry) else $error("program entered while running");
	property p_no_cross; $past(st) != PROGRAM_IDLE_STATE && st != PROGRAM_IDLE_STATE |-> st == $past(st); endproperty
	a_no_cross: assert property (p_no_cross) else $error("direct run/download switch");
	property p_quiet; quiet_q > QUIET |-> $stable(terminal_functions) && $stable(st); endproperty
	a_quiet: assert property (p_quiet) else $error("outputs moved with quiet inputs");
	property p_no_quick; !QUICK_STOP_VARIANT |-> !terminal_functions.quick_stop; endproperty
	a_no_quick: assert property (p_no_quick) else $error("quick stop in wrong variant");
	c_run: cover property (st == PROGRAM_RUN_STATE);
	c_download: cover property (st == PROGRAM_DOWNLOAD_STATE);
	c_speed_top: cover property (terminal_functions.speed_index == 4'hF);
	c_stop: cover property (program_out.motor_stop_request);
endmodule : drive_input_terminal_decode_props

bind drive_input_terminal_decode drive_input_terminal_decode_props #(
	.NUM_TERMINALS(NUM_TERMINALS), .STEP_CYCLES(STEP_CYCLES), .QUICK_STOP_VARIANT(QUICK_STOP_VARIANT)
) props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.input_terminals(input_terminals), .drive_stopped(drive_stopped),
	.terminal_functions(terminal_functions), .program_out(program_out)
);

/* contact_bank.sv */
// External contacts on the terminal pins; moving contacts chatter before settling.
// Assumes target and bounce_len change just after a rising clock edge.
`timescale 1ns/1ps
module contact_bank (
	input wire logic pclk,
	input wire logic [5:0] target,
	input wire logic [3:0] bounce_len,
	output logic [5:0] pins
);
	logic [5:0] last_q = 6'h00;
	logic [5:0] moved_q = 6'h00;
	logic [3:0] left_q = 4'h0;
	logic [5:0] pins_q = 6'h00;
	assign pins = pins_q;
	// Chatter on alternate cycles mimics a real contact, never kinder
	always @(posedge pclk) begin
		if (target != last_q) begin
			last_q <= target;
			moved_q <= target ^ last_q;
			left_q <= bounce_len;
		end else if (left_q != 4'h0) begin
			left_q <= left_q - 4'h1;
		end
		pins_q <= left_q[0] ? (target ^ moved_q) : target;
	end
endmodule : contact_bank

/* drive_input_terminal_decode_tb.sv */
// Self-checking bench for the input terminal decoder: registers, speed and
// motor decode, polarity, debounce and program state control.
// Assumes the package, decoder, checker and contact_bank are compiled first.
`timescale 1ns/1ps
module drive_input_terminal_decode_tb;
	import drive_input_pkg::*;
	// Short debounce step keeps every settle to a few dozen cycles
	localparam int STEP = 4;
	localparam logic [4:0] PSEQ [7] = '{5'h04, 5'h15, 5'h1D, 5'h1B, 5'h1F, 5'h1B, 5'h10};
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [5:0] pins;
	logic [5:0] target = 6'h00;
	logic [3:0] bounce = 4'h0;
	logic drive_stopped = 1'b0;
	terminal_fn_t tfn;
	terminal_fn_t tfn_qs;
	program_out_t pout;
	logic [32:0] exp_q[$];
	logic [32:0] e;
	logic [5:0] lv;
	logic [5:0] pol;
	logic [2:0] src;
	int fails = 0;
	int checks_done = 0;
	int cycles = 0;
	int dbn = 1;

	always #5 pclk = ~pclk;

	contact_bank contacts (.pclk(pclk), .target(target), .bounce_len(bounce), .pins(pins));
	drive_input_terminal_decode #(.STEP_CYCLES(STEP)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.input_terminals(pins), .drive_stopped(drive_stopped), .terminal_functions(tfn),
		.program_out(pout)
	);
	drive_input_terminal_decode #(.STEP_CYCLES(STEP), .QUICK_STOP_VARIANT(1'b1)) dut_qs (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
		.input_terminals(pins), .drive_stopped(drive_stopped), .terminal_functions(tfn_qs),
		.program_out()
	);

	task chk(input string what, input logic [32:0] x, input logic [32:0] g);
		checks_done++;
		if (g !== x) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, x, g);
		end
	endtask : chk

	task test_done;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done

	// Run takes about 1240 cycles
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 8000) begin
			fails++;
			test_done();
		end
	end

	// Each read answer is matched with the oldest noted expectation
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && pready === 1'b1) begin
			e = exp_q.pop_front();
			chk("prdata", e, {pslverr, prdata});
			if (paddr == OFS_STATUS) begin
				chk("fn", {25'h0, e[23:20], e[24], e[26:25], e[27]}, {25'h0, tfn});
				chk("state", {31'h0, e[17:16]}, {31'h0, pout.state});
			end
		end
	end

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task rd(input logic [7:0] a, input logic [32:0] x);
		exp_q.push_back(x);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd

	task pinset(input logic [5:0] v);
		target <= v;
		repeat (bounce + dbn * STEP + 8) @(posedge pclk);
	endtask : pinset

	function logic [32:0] st(input logic [5:0] l, input logic [1:0] s, input logic [3:0] spd,
		input logic [1:0] mot);
		st = 33'h0;
		st[5:0] = l;
		st[17:16] = s;
		st[23:20] = spd;
		st[24] = (spd == 4'h0);
		st[26:25] = mot;
	endfunction : st

	task kp(input logic [31:0] d, input logic [1:0] s);
		apb(1'b1, OFS_CONTROL, d);
		repeat (4) @(posedge pclk);
		rd(OFS_STATUS, st(6'h00, s, 4'h0, 2'h0));
	endtask : kp

	initial begin
		void'($urandom(32'h9E59C24B));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFS_POLARITY, {21'h0, POLARITY_RESET});
		rd(OFS_DEBOUNCE, {28'h0, DEBOUNCE_RESET});
		rd(OFS_STATUS, st(6'h00, PROGRAM_IDLE_STATE, 4'h0, 2'h0));
		rd(8'h14, {1'b1, 32'h0000_0000});
		apb(1'b1, OFS_POLARITY, 32'hFFFF_FFFF);
		rd(OFS_POLARITY, 33'h0_0000_0FFF);
		apb(1'b1, OFS_DEBOUNCE, 32'h0000_0000);
		rd(OFS_DEBOUNCE, {28'h0, DEBOUNCE_MIN});
		apb(1'b1, OFS_DEBOUNCE, 32'h0000_001F);
		rd(OFS_DEBOUNCE, {28'h0, DEBOUNCE_MAX});
		apb(1'b1, OFS_DEBOUNCE, 32'h0000_0003);
		dbn = 3;
		apb(1'b1, OFS_FUNCTION, {2'b0, FN_MOTOR_BIT1, FN_MOTOR_BIT0, 5'h04, 5'h03, 5'h02, FN_SPEED_BIT0});
		for (int i = 0; i < 24; i++) begin
			lv = 6'($urandom);
			if (i < 16) lv[3:0] = i[3:0];
			pol = 6'($urandom);
			src = 3'($urandom_range(2, 0));
			bounce <= 4'($urandom_range(5, 0));
			apb(1'b1, OFS_CONTROL, {29'h0, src});
			apb(1'b1, OFS_POLARITY, {26'h0, pol});
			pinset(lv ^ ((src == 3'h0) ? pol : (pol & 6'h38)));
			rd(OFS_STATUS, st(lv, PROGRAM_IDLE_STATE, lv[3:0], lv[5:4]));
		end
		bounce <= 4'h0;
		apb(1'b1, OFS_CONTROL, 32'h0000_0000);
		apb(1'b1, OFS_POLARITY, 32'h0000_0000);
		pinset(6'h00);
		// A pulse shorter than the debounce time must leave no trace
		target <= 6'h3F;
		repeat (4) @(posedge pclk);
		pinset(6'h00);
		rd(OFS_STATUS, st(6'h00, PROGRAM_IDLE_STATE, 4'h0, 2'h0));
		target <= 6'h01;
		@(posedge pclk);
		rd(OFS_STATUS, st(6'h00, PROGRAM_IDLE_STATE, 4'h0, 2'h0));
		repeat (dbn * STEP + 4) @(posedge pclk);
		rd(OFS_STATUS, st(6'h01, PROGRAM_IDLE_STATE, 4'h1, 2'h0));
		apb(1'b1, OFS_FUNCTION, {22'h0, FN_PROGRAM_DOWNLOAD, FN_PROGRAM_RUN});
		for (int i = 0; i < 7; i++) begin
			drive_stopped <= PSEQ[i][4];
			pinset({4'h0, PSEQ[i][3:2]});
			rd(OFS_STATUS, st({4'h0, PSEQ[i][3:2]}, PSEQ[i][1:0], 4'h0, 2'h0));
		end
		// The keypad gate looks at the source already in force
		apb(1'b1, OFS_CONTROL, 32'h0000_0001);
		kp(32'h0000_0501, PROGRAM_IDLE_STATE);
		apb(1'b1, OFS_CONTROL, 32'h0000_0000);
		kp(32'h0000_0500, PROGRAM_RUN_STATE);
		kp(32'h0000_0410, PROGRAM_IDLE_STATE);
		chk("stop method", 33'h1, {32'h0, pout.stop_method});
		// Quick stop variant acts on its code only under source five
		apb(1'b1, OFS_CONTROL, {29'h0, CMD_SRC_QUICK_STOP});
		apb(1'b1, OFS_FUNCTION, {27'h0, FN_QUICK_STOP});
		pinset(6'h01);
		chk("quick stop", 33'h1, {32'h0, tfn_qs.quick_stop});
		chk("quick stop plain", 33'h0, {32'h0, tfn.quick_stop});
		apb(1'b1, OFS_CONTROL, 32'h0000_0000);
		repeat (2) @(posedge pclk);
		chk("quick stop source", 33'h0, {32'h0, tfn_qs.quick_stop});
		repeat (120) @(posedge pclk);
		test_done();
	end
endmodule : drive_input_terminal_decode_tb
